// >>> pkg/nsid_pkg.sv
// Package of constants and types for the network status indicator driver.
package nsid_pkg;

  localparam int unsigned NSID_NUM_PORTS = 2;

  // Pattern timing in milliseconds; each count is derived from the 100 MHz clock.
  localparam int unsigned NSID_CLK_HZ          = 100000000;
  localparam int unsigned NSID_FLICKER_MS      = 50;
  localparam int unsigned NSID_BLINK_MS        = 200;
  localparam int unsigned NSID_FLASH_ON_MS     = 200;
  localparam int unsigned NSID_FLASH_GAP_MS    = 200;
  localparam int unsigned NSID_FLASH_PAUSE_MS  = 1000;
  localparam int unsigned NSID_FLICKER_CYC     = NSID_CLK_HZ / 1000 * NSID_FLICKER_MS;
  localparam int unsigned NSID_BLINK_CYC       = NSID_CLK_HZ / 1000 * NSID_BLINK_MS;
  localparam int unsigned NSID_FLASH_ON_CYC    = NSID_CLK_HZ / 1000 * NSID_FLASH_ON_MS;
  localparam int unsigned NSID_FLASH_GAP_CYC   = NSID_CLK_HZ / 1000 * NSID_FLASH_GAP_MS;
  localparam int unsigned NSID_FLASH_PAUSE_CYC = NSID_CLK_HZ / 1000 * NSID_FLASH_PAUSE_MS;

  localparam int unsigned NSID_CNT_W = 27;

  // Network state machine codes on the state input.
  localparam logic [2:0] NSID_ST_STARTUP = 3'h1;
  localparam logic [2:0] NSID_ST_PREP    = 3'h2;
  localparam logic [2:0] NSID_ST_BOOT    = 3'h3;
  localparam logic [2:0] NSID_ST_SAFE    = 3'h4;
  localparam logic [2:0] NSID_ST_RUN     = 3'h5;

  // Display unit codes.
  localparam logic [1:0] NSID_UNIT_BAR    = 2'h0;
  localparam logic [1:0] NSID_UNIT_PSIA   = 2'h1;
  localparam logic [1:0] NSID_UNIT_MPA    = 2'h2;
  localparam logic [1:0] NSID_UNIT_CUSTOM = 2'h3;

  typedef enum logic [4:0] {
    NSID_ERR_NONE  = 5'h01,
    NSID_ERR_WDOG  = 5'h02,
    NSID_ERR_LOCAL = 5'h04,
    NSID_ERR_CFG   = 5'h08,
    NSID_ERR_CRIT  = 5'h10
  } nsid_err_e;

endpackage

// >>> design/nsid_top.sv
// Status lamp driver: link/activity, run, error and display unit lamps.
`timescale 1ns/1ps
module nsid_top
  import nsid_pkg::*;
#(
  parameter int unsigned FLICKER_CYC     = nsid_pkg::NSID_FLICKER_CYC,
  parameter int unsigned BLINK_CYC       = nsid_pkg::NSID_BLINK_CYC,
  parameter int unsigned FLASH_ON_CYC    = nsid_pkg::NSID_FLASH_ON_CYC,
  parameter int unsigned FLASH_GAP_CYC   = nsid_pkg::NSID_FLASH_GAP_CYC,
  parameter int unsigned FLASH_PAUSE_CYC = nsid_pkg::NSID_FLASH_PAUSE_CYC
) (
  input  wire logic                                clk_sys,
  input  wire logic                                rst,
  input  wire logic                                clk_en,
  input  wire logic [nsid_pkg::NSID_NUM_PORTS-1:0] port_link,
  input  wire logic [nsid_pkg::NSID_NUM_PORTS-1:0] port_activity,
  input  wire logic [2:0]                          network_state_machine,
  input  wire logic                                fw_download,
  input  wire logic                                err_wdog,
  input  wire logic                                err_local,
  input  wire logic                                err_cfg,
  input  wire logic                                err_crit,
  input  wire logic                                err_clear,
  input  wire logic [1:0]                          local_unit,
  output logic      [nsid_pkg::NSID_NUM_PORTS-1:0] lamp_link,
  output logic                                     lamp_run,
  output logic                                     lamp_err,
  output logic                                     lamp_bar,
  output logic                                     lamp_psia,
  output logic                                     lamp_mpa
);
  import nsid_pkg::*;

  localparam int unsigned NP = NSID_NUM_PORTS;

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for all status inputs, which come from other logic
  // or pins not guaranteed to share this clock. Each group has its own pair of
  // stages, and only the second stage of a pair is read by the lamp logic.

  logic [2*NP-1:0] port_meta_reg;
  logic [2*NP-1:0] port_sync_reg;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      port_meta_reg <= '0;
      port_sync_reg <= '0;
    end else if (clk_en) begin
      port_meta_reg <= {port_link, port_activity};
      port_sync_reg <= port_meta_reg;
    end
  end

  logic [3:0] state_meta_reg;
  logic [3:0] state_sync_reg;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_meta_reg <= '0;
      state_sync_reg <= '0;
    end else if (clk_en) begin
      state_meta_reg <= {network_state_machine, fw_download};
      state_sync_reg <= state_meta_reg;
    end
  end

  logic [4:0] err_meta_reg;
  logic [4:0] err_sync_reg;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      err_meta_reg <= '0;
      err_sync_reg <= '0;
    end else if (clk_en) begin
      err_meta_reg <= {err_wdog, err_local, err_cfg, err_crit, err_clear};
      err_sync_reg <= err_meta_reg;
    end
  end

  logic [1:0] unit_meta_reg;
  logic [1:0] unit_sync_reg;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      unit_meta_reg <= '0;
      unit_sync_reg <= '0;
    end else if (clk_en) begin
      unit_meta_reg <= local_unit;
      unit_sync_reg <= unit_meta_reg;
    end
  end

  logic [NP-1:0] s_link;
  logic [NP-1:0] s_act;
  logic [2:0]    s_state;
  logic          s_fw;
  logic [3:0]    s_err;
  logic          s_clear;
  logic [1:0]    s_unit;

  assign {s_link, s_act}  = port_sync_reg;
  assign {s_state, s_fw}  = state_sync_reg;
  assign {s_err, s_clear} = err_sync_reg;
  assign s_unit           = unit_sync_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Pattern generators, shared by the link, run and error lamps so that lamps stay in phase.

  function automatic logic cnt_wrap(input logic [NSID_CNT_W-1:0] cnt,
                                    input int unsigned           period);
    cnt_wrap = (cnt >= NSID_CNT_W'(period - 1));
  endfunction

  logic [NSID_CNT_W-1:0] flick_cnt_reg;
  logic                  flick_reg;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flick_cnt_reg <= '0;
      flick_reg     <= 1'b0;
    end else if (clk_en) begin
      if (cnt_wrap(flick_cnt_reg, FLICKER_CYC)) begin
        flick_cnt_reg <= '0;
        flick_reg     <= ~flick_reg;
      end else begin
        flick_cnt_reg <= flick_cnt_reg + 1'b1;
      end
    end
  end

  logic [NSID_CNT_W-1:0] blink_cnt_reg;
  logic                  blink_reg;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      blink_cnt_reg <= '0;
      blink_reg     <= 1'b0;
    end else if (clk_en) begin
      if (cnt_wrap(blink_cnt_reg, BLINK_CYC)) begin
        blink_cnt_reg <= '0;
        blink_reg     <= ~blink_reg;
      end else begin
        blink_cnt_reg <= blink_cnt_reg + 1'b1;
      end
    end
  end

  // Flash sequencer: first flash, gap, second flash, long pause. Single flash
  // lights only in the first flash, double flash in both flashes, so both
  // patterns share one period and one counter.
  typedef enum logic [3:0] {
    NSID_FL_ON1   = 4'h1,
    NSID_FL_GAP   = 4'h2,
    NSID_FL_ON2   = 4'h4,
    NSID_FL_PAUSE = 4'h8
  } nsid_flash_e;

  logic [NSID_CNT_W-1:0] flash_cnt_reg;
  nsid_flash_e           flash_ph_reg;
  nsid_flash_e           flash_ph_next;
  logic                  flash_wrap;

  always_comb begin
    case (flash_ph_reg)
      NSID_FL_ON1: begin
        flash_wrap    = cnt_wrap(flash_cnt_reg, FLASH_ON_CYC);
        flash_ph_next = NSID_FL_GAP;
      end
      NSID_FL_GAP: begin
        flash_wrap    = cnt_wrap(flash_cnt_reg, FLASH_GAP_CYC);
        flash_ph_next = NSID_FL_ON2;
      end
      NSID_FL_ON2: begin
        flash_wrap    = cnt_wrap(flash_cnt_reg, FLASH_ON_CYC);
        flash_ph_next = NSID_FL_PAUSE;
      end
      NSID_FL_PAUSE: begin
        flash_wrap    = cnt_wrap(flash_cnt_reg, FLASH_PAUSE_CYC);
        flash_ph_next = NSID_FL_ON1;
      end
      default: begin
        // An illegal code restarts the sequence at once rather than hanging.
        flash_wrap    = 1'b1;
        flash_ph_next = NSID_FL_ON1;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flash_cnt_reg <= '0;
      flash_ph_reg  <= NSID_FL_ON1;
    end else if (clk_en) begin
      if (flash_wrap) begin
        flash_cnt_reg <= '0;
        flash_ph_reg  <= flash_ph_next;
      end else begin
        flash_cnt_reg <= flash_cnt_reg + 1'b1;
      end
    end
  end

  logic single_flash;
  logic double_flash;

  assign single_flash = (flash_ph_reg == NSID_FL_ON1);
  assign double_flash = (flash_ph_reg == NSID_FL_ON1) || (flash_ph_reg == NSID_FL_ON2);

  ////////////////////////////////////////////////////////////////////////////
  // Link/activity lamps, one per port.

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lamp_link <= '0;
    end else if (clk_en) begin
      for (int i = 0; i < NP; i++) begin
        // Each lamp sees only its own port's link and activity.
        lamp_link[i] <= s_link[i] & (~s_act[i] | flick_reg);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Run lamp.

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lamp_run <= 1'b0;
    end else if (clk_en) begin
      case (s_state)
        NSID_ST_STARTUP: lamp_run <= 1'b0;
        NSID_ST_PREP:    lamp_run <= blink_reg;
        NSID_ST_SAFE:    lamp_run <= single_flash;
        NSID_ST_RUN:     lamp_run <= 1'b1;
        NSID_ST_BOOT:    lamp_run <= s_fw & flick_reg;
        default:         lamp_run <= 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error latch: the first error seen is held until the clear input. Later
  // errors are ignored. A new error in the clear cycle is latched, so no
  // event is lost; priority among simultaneous first errors is critical,
  // configuration, local, watchdog.

  nsid_err_e err_reg;
  nsid_err_e err_next;

  always_comb begin
    err_next = err_reg;
    if (s_clear) begin
      err_next = NSID_ERR_NONE;
    end
    if ((err_reg == NSID_ERR_NONE) || s_clear) begin
      if (s_err[0]) begin
        err_next = NSID_ERR_CRIT;
      end else if (s_err[1]) begin
        err_next = NSID_ERR_CFG;
      end else if (s_err[2]) begin
        err_next = NSID_ERR_LOCAL;
      end else if (s_err[3]) begin
        err_next = NSID_ERR_WDOG;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      err_reg <= NSID_ERR_NONE;
    end else if (clk_en) begin
      err_reg <= err_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lamp_err <= 1'b0;
    end else if (clk_en) begin
      case (err_reg)
        NSID_ERR_NONE:  lamp_err <= 1'b0;
        NSID_ERR_WDOG:  lamp_err <= double_flash;
        NSID_ERR_LOCAL: lamp_err <= single_flash;
        NSID_ERR_CFG:   lamp_err <= blink_reg;
        NSID_ERR_CRIT:  lamp_err <= 1'b1;
        default:        lamp_err <= 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Display unit lamps follow only the local display unit; the network unit
  // has no path here at all.

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lamp_bar  <= 1'b0;
      lamp_psia <= 1'b0;
      lamp_mpa  <= 1'b0;
    end else if (clk_en) begin
      lamp_bar  <= (s_unit == NSID_UNIT_BAR);
      lamp_psia <= (s_unit == NSID_UNIT_PSIA);
      lamp_mpa  <= (s_unit == NSID_UNIT_MPA);
    end
  end

endmodule // nsid_top

// >>> dv/nsid_lamp_watch.sv
// Operator model of the lamps: counts lit samples and turn-ons over a window.
`timescale 1ns/1ps
module nsid_lamp_watch (
  input  wire logic       clk_sys,
  input  wire logic       clr,
  input  wire logic [3:0] lamp,
  output logic      [7:0] on_cnt [4],
  output logic      [7:0] up_cnt [4]
);
  logic [3:0] prev_reg;
  // The previous sample is kept across a clear so that a window of whole periods counts exactly.
  always_ff @(posedge clk_sys) begin
    prev_reg <= lamp;
    for (int i = 0; i < 4; i++) begin
      on_cnt[i] <= clr ? 8'h00 : on_cnt[i] + 8'(lamp[i]);
      up_cnt[i] <= clr ? 8'h00 : up_cnt[i] + 8'(lamp[i] & ~prev_reg[i]);
    end
  end
endmodule // nsid_lamp_watch

// >>> dv/nsid_top_checker.sv
// Checker of input to lamp relations at the ports of the status lamp driver.
`timescale 1ns/1ps
module nsid_top_checker
  import nsid_pkg::*;
(
  input wire logic                                clk_sys,
  input wire logic                                rst,
  input wire logic                                clk_en,
  input wire logic [nsid_pkg::NSID_NUM_PORTS-1:0] port_link,
  input wire logic [nsid_pkg::NSID_NUM_PORTS-1:0] port_activity,
  input wire logic [2:0]                          network_state_machine,
  input wire logic                                fw_download,
  input wire logic                                err_wdog,
  input wire logic                                err_local,
  input wire logic                                err_cfg,
  input wire logic                                err_crit,
  input wire logic                                err_clear,
  input wire logic [1:0]                          local_unit,
  input wire logic [nsid_pkg::NSID_NUM_PORTS-1:0] lamp_link,
  input wire logic                                lamp_run,
  input wire logic                                lamp_err,
  input wire logic                                lamp_bar,
  input wire logic                                lamp_psia,
  input wire logic                                lamp_mpa
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Three samples cover the two synchroniser stages and the lamp register.
  sequence s_quiet;
    !err_wdog && !err_local && !err_cfg && !err_crit;
  endsequence
  sequence s_clear_crit;
    err_clear && err_crit;
  endsequence
  link_off_a: assert property ((!port_link[0])[*3] |=> !lamp_link[0])
    else $error("link lamp lit without link");
  link_on_a: assert property ((port_link[1] && !port_activity[1])[*3] |=> lamp_link[1])
    else $error("link lamp dark on idle link");
  port_apart_a: assert property ((!port_link[0] && port_link[1] && !port_activity[1])[*3]
    |=> !lamp_link[0] && lamp_link[1]) else $error("link lamps not independent");
  run_dark_a: assert property ((network_state_machine == NSID_ST_STARTUP)[*3] |=> !lamp_run)
    else $error("run lamp lit in startup");
  run_lit_a: assert property ((network_state_machine == NSID_ST_RUN)[*3] |=> lamp_run)
    else $error("run lamp dark while running");
  unit_bar_a: assert property ((local_unit == NSID_UNIT_BAR)[*3]
    |=> lamp_bar && !lamp_psia && !lamp_mpa) else $error("bar unit lamps wrong");
  unit_custom_a: assert property ((local_unit == NSID_UNIT_CUSTOM)[*3]
    |=> !lamp_bar && !lamp_psia && !lamp_mpa) else $error("unit lamp lit for custom unit");
  err_crit_a: assert property (s_clear_crit ##1 (!err_clear)[*4] |-> lamp_err)
    else $error("error lamp dark after critical error");
  err_dark_a: assert property (err_clear ##0 s_quiet ##1 s_quiet[*4] |-> !lamp_err)
    else $error("error lamp lit with no error");
  freeze_hold_a: assert property (!clk_en |=> $stable(lamp_link) && $stable(lamp_run)
    && $stable(lamp_err) && $stable(lamp_bar) && $stable(lamp_psia) && $stable(lamp_mpa))
    else $error("lamp moved while clock enable low");
endmodule // nsid_top_checker
bind nsid_top nsid_top_checker u_nsid_chk (.*);

// >>> dv/network_status_indicator_driver_bench.sv
// Self-checking bench for the status lamp driver.
`timescale 1ns/1ps
module network_status_indicator_driver_bench;
  import nsid_pkg::*;
  logic       clk_sys = 1'b0, rst = 1'b1, clr = 1'b0, fw = 1'b0, e_clr = 1'b0;
  logic       en = 1'b1;
  logic [6:0] snap;
  logic [1:0] link = 2'h0, act = 2'h0, unit = 2'h0, ll;
  logic [2:0] st = 3'h0;
  logic [3:0] errs = 4'h0;
  logic       run, el, lb, lp, lm;
  logic [7:0] on_cnt [4], up_cnt [4];
  int         err_total = 0, cmp_count = 0;
  nsid_top #(.FLICKER_CYC(4), .BLINK_CYC(8), .FLASH_ON_CYC(8), .FLASH_GAP_CYC(8),
    .FLASH_PAUSE_CYC(32)) DUT (.clk_sys(clk_sys), .rst(rst), .clk_en(en), .port_link(link),
    .port_activity(act), .network_state_machine(st), .fw_download(fw), .err_wdog(errs[0]),
    .err_local(errs[1]), .err_cfg(errs[2]), .err_crit(errs[3]), .err_clear(e_clr),
    .local_unit(unit), .lamp_link(ll), .lamp_run(run), .lamp_err(el), .lamp_bar(lb),
    .lamp_psia(lp), .lamp_mpa(lm));
  nsid_lamp_watch u_watch (.clk_sys(clk_sys), .clr(clr), .lamp({el, run, ll}),
    .on_cnt(on_cnt), .up_cnt(up_cnt));
  // Pattern codes: 0 off, 1 on, 2 flicker, 3 blink, 4 single flash, 5 double flash.
  // A 112 cycle window holds whole periods of every pattern, so the counts are exact.
  function automatic logic [7:0] exp_on(int p);
    return (p == 1) ? 8'h70 : (p == 2 || p == 3) ? 8'h38 : (p == 4) ? 8'h10 :
      (p == 5) ? 8'h20 : 8'h00;
  endfunction
  function automatic logic [7:0] exp_up(int p);
    return (p == 2) ? 8'h0E : (p == 3) ? 8'h07 : (p == 4) ? 8'h02 : (p == 5) ? 8'h04 : 8'h00;
  endfunction
  function automatic int run_pat(logic [2:0] s, logic f);
    return (s == NSID_ST_PREP) ? 3 : (s == NSID_ST_SAFE) ? 4 : (s == NSID_ST_RUN) ? 1 :
      (s == NSID_ST_BOOT && f) ? 2 : 0;
  endfunction
  function automatic int link_pat(logic l, logic a);
    return l ? (a ? 2 : 1) : 0;
  endfunction
  task automatic chk(string name, logic [7:0] expv, logic [7:0] got);
    cmp_count++;
    if (got !== expv) begin
      err_total++;
      $display("mismatch %s expected %0h seen %0h", name, expv, got);
    end
  endtask
  task automatic measure(int pe);
    int pat [4];
    pat = '{link_pat(link[0], act[0]), link_pat(link[1], act[1]), run_pat(st, fw), pe};
    repeat (6) @(posedge clk_sys);
    clr <= 1'b1;
    @(posedge clk_sys);
    clr <= 1'b0;
    repeat (112) @(posedge clk_sys);
    #1;
    for (int i = 0; i < 4; i++) begin
      chk("lamp lit cycles", exp_on(pat[i]), on_cnt[i]);
      chk("lamp turn-ons", exp_up(pat[i]), up_cnt[i]);
    end
  endtask
  task automatic raise(logic [3:0] e, logic c);
    @(posedge clk_sys);
    errs <= e;
    e_clr <= c;
    @(posedge clk_sys);
    errs <= 4'h0;
    e_clr <= 1'b0;
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #100000;
    err_total++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'h1CEC));
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    // Every state code with and without download; link, activity random; units in turn.
    for (int n = 0; n < 16; n++) begin
      @(posedge clk_sys);
      st <= 3'(n);
      fw <= n[3];
      unit <= 2'(n);
      link <= 2'($urandom);
      act <= 2'($urandom);
      #1;
      measure(0);
      chk("bar lamp", 8'(unit == NSID_UNIT_BAR), 8'(lb));
      chk("psia lamp", 8'(unit == NSID_UNIT_PSIA), 8'(lp));
      chk("mpa lamp", 8'(unit == NSID_UNIT_MPA), 8'(lm));
    end
    for (int k = 0; k < 4; k++) begin
      raise(4'(1 << k), 1'b1);
      measure((k == 3) ? 1 : 5 - k);
    end
    raise(4'hF, 1'b1);
    measure(1);
    raise(4'h1, 1'b1);
    raise(4'h8, 1'b0);
    measure(5);
    raise(4'h0, 1'b1);
    measure(0);
    // A frozen block must hold every lamp and miss an error pulse.
    @(posedge clk_sys);
    st <= NSID_ST_PREP;
    link <= 2'h3;
    act <= 2'($urandom);
    repeat (8) @(posedge clk_sys);
    en <= 1'b0;
    @(posedge clk_sys);
    #1;
    snap = {el, run, ll, lb, lp, lm};
    for (int n = 0; n < 40; n++) begin
      @(posedge clk_sys);
      errs <= (n == 5) ? 4'h8 : 4'h0;
      #1;
      chk("frozen lamps", 8'(snap), 8'({el, run, ll, lb, lp, lm}));
    end
    @(posedge clk_sys);
    en <= 1'b1;
    #1;
    measure(0);
    give_verdict();
  end
endmodule // network_status_indicator_driver_bench
